// >>> inc/tisg_pkg.sv
// Package with register map, field positions, reset values and mode type
package tisg_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TOUCH_GROUP_IRQ_ENABLE = 8'h27;
  localparam logic [7:0] ADDR_GP_INPUT_IRQ_ENABLE    = 8'h28;
  localparam logic [7:0] ADDR_SLEEP_SAMPLING_SELECT  = 8'h29;
  localparam logic [7:0] ADDR_SIMULTANEOUS_TOUCH_CFG = 8'h2A;
  // Reset values
  localparam logic [7:0] RST_TOUCH_GROUP_IRQ_ENABLE  = 8'hFF;
  localparam logic [7:0] RST_GP_INPUT_IRQ_ENABLE     = 8'h00;
  localparam logic [7:0] RST_SLEEP_SAMPLING_SELECT   = 8'h00;
  localparam logic [7:0] RST_SIMULTANEOUS_TOUCH_CFG  = 8'h82;
  // Field positions
  localparam int GROUP_BIT          = 7;
  localparam int BLOCK_EN_BIT       = 7;
  localparam int BUTTON_LIMIT_LSB   = 2;
  localparam int GROUPED_LIMIT_LSB  = 0;
  localparam int NUM_BUTTONS        = 7;
  localparam int NUM_GROUPED        = 7;
  localparam int NUM_GP_INPUTS      = 8;
  // Mode of the sensing core
  typedef enum logic [1:0] {
    TISG_ACTIVE = 2'b01,
    TISG_SLEEP  = 2'b10
  } tisg_mode_t;
endpackage

// >>> sim/tisg_host_model.sv
// Host model that acknowledges by clearing all status
`timescale 1ns/1ps
module tisg_host_model (
  input  wire logic       mclk_in,
  input  wire logic       ack_in,
  output logic      [7:0] status_clear_out
);
  // One clear pulse per request; recalibration of woken channels is left to the host flow
  always_ff @(posedge mclk_in) begin
    status_clear_out <= ack_in ? 8'hFF : 8'h00;
  end
endmodule

// >>> sim/tisg_irq_chk.sv
// Port checker for the interrupt gating block
`timescale 1ns/1ps
module tisg_irq_chk (
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       sleep_in,
  input wire logic [6:0] button_touch_in,
  input wire logic [6:0] grouped_sensor_en_in,
  input wire logic [7:0] gp_input_set_in,
  input wire logic [7:0] status_clear_in,
  input wire logic [7:0] touch_status_out,
  input wire logic [7:0] gp_input_status_out,
  input wire logic [6:0] button_sample_out,
  input wire logic [6:0] grouped_sample_out,
  input wire logic       button_multi_event_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Read of the touch configuration byte
  sequence s_rd_cfg;
    reg_rd_in && reg_addr_in == 8'h2A;
  endsequence
  property p_cfg_gap; s_rd_cfg |=> reg_rdata_out[6:4] == 3'h0; endproperty
  property p_irq_src; irq_out |-> (|{touch_status_out, gp_input_status_out}); endproperty
  property p_sticky;
    status_clear_in == 8'h00 |=> (touch_status_out & $past(touch_status_out)) == $past(touch_status_out);
  endproperty
  // Mode lags the sleep level by one edge and the sample select by one more
  property p_active; !$past(sleep_in) |=> button_sample_out == 7'h7F; endproperty
  property p_grp; 1'b1 |=> (grouped_sample_out & ~$past(grouped_sensor_en_in)) == 7'h00; endproperty
  property p_btn_new;
    (touch_status_out[6:0] & ~$past(touch_status_out[6:0]) & ~$past(button_touch_in, 2)) == 7'h00;
  endproperty
  property p_gp_new;
    (gp_input_status_out & ~$past(gp_input_status_out) & ~$past(gp_input_set_in)
     & ~$past(gp_input_set_in, 2)) == 8'h00;
  endproperty
  property p_multi; button_multi_event_out |-> $countones($past(button_touch_in, 2)) >= 2; endproperty
  a_cfg_gap: assert property (p_cfg_gap) else $error("config spare bits read nonzero");
  a_irq_src: assert property (p_irq_src) else $error("irq without status");
  a_sticky: assert property (p_sticky) else $error("status bit lost");
  a_active: assert property (p_active) else $error("active mode misses buttons");
  a_grp: assert property (p_grp) else $error("disabled grouped sensor sampled");
  a_btn_new: assert property (p_btn_new) else $error("button status without touch");
  a_gp_new: assert property (p_gp_new) else $error("input status without set");
  a_multi: assert property (p_multi) else $error("multi flag with one touch");
endmodule
bind tisg_irq_ctrl tisg_irq_chk u_chk (.mclk_in, .resetn_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .sleep_in, .button_touch_in, .grouped_sensor_en_in, .gp_input_set_in,
  .status_clear_in, .touch_status_out, .gp_input_status_out, .button_sample_out,
  .grouped_sample_out, .button_multi_event_out, .irq_out);

// >>> sim/tisg_irq_ctrl_tb_top.sv
// Self-checking bench for interrupt gating, sleep select and multi touch
`timescale 1ns/1ps
module tisg_irq_ctrl_tb_top;
  logic        mclk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0, sleep_in = 0, ack = 0;
  logic [7:0]  reg_addr_in = 0, reg_wdata_in = 0, gp_input_set_in = 0, r, g;
  logic [6:0]  button_touch_in = 0, grouped_touch_in = 0, grouped_sensor_en_in = 7'h7F;
  logic [3:0]  group_gesture_in = 0;
  logic [7:0]  reg_rdata_out, status_clear_in, touch_status_out, gp_input_status_out;
  logic [6:0]  button_sample_out, grouped_sample_out;
  logic        button_multi_event_out, grouped_multi_event_out, irq_out;
  logic [31:0] seed = 32'hDA0D58B6;
  int          num_errors = 0, checks_done = 0;
  tisg_irq_ctrl u_dut (.mclk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .sleep_in, .button_touch_in, .grouped_touch_in, .grouped_sensor_en_in,
    .group_gesture_in, .gp_input_set_in, .status_clear_in, .touch_status_out,
    .gp_input_status_out, .button_sample_out, .grouped_sample_out, .button_multi_event_out,
    .grouped_multi_event_out, .irq_out);
  tisg_host_model u_host (.mclk_in, .ack_in(ack), .status_clear_out(status_clear_in));
  always #10 mclk_in = ~mclk_in;
  // Xorshift source and grouped limit decode
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int glim(logic [1:0] c);
    return (c == 2'h3) ? 1 : int'(c) + 2;
  endfunction
  // Compare, bus and pacing tasks
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1;
    @(posedge mclk_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1;
    @(posedge mclk_in);
    reg_rd_in <= 0;
    #1 r = reg_rdata_out;
  endtask
  task automatic clr();
    @(posedge mclk_in);
    {button_touch_in, grouped_touch_in, group_gesture_in, gp_input_set_in} <= '0;
    step(2);
    ack <= 1;
    @(posedge mclk_in);
    ack <= 0;
    step(3);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog for a hung run
  initial begin
    #1ms;
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    logic [7:0] ad[5] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h30};
    logic [7:0] ex[5] = '{8'hFF, 8'h00, 8'h00, 8'h82, 8'h00};
    step(8);
    resetn_in <= 1;
    foreach (ad[i]) begin
      rd(ad[i]);
      chk("reset value", r, ex[i]);
    end
    g = 8'h01 << (rnd() % 7);
    wr(8'h27, 8'h00);
    button_touch_in <= g[6:0];
    step(4);
    chk("button status", touch_status_out, g);
    chk("masked irq", irq_out, 0);
    wr(8'h27, g);
    step(2);
    chk("enabled irq", irq_out, 1);
    clr();
    wr(8'h27, 8'h80);
    grouped_touch_in <= 7'h01;
    group_gesture_in <= 4'h1;
    step(4);
    chk("group status", touch_status_out[7], 1);
    chk("group irq", irq_out, 1);
    wr(8'h27, 8'h7F);
    step(2);
    chk("group irq off", irq_out, 0);
    clr();
    $display("enable tests done");
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      g = rnd() | 8'h01;
      wr(8'h28, r);
      gp_input_set_in <= g;
      @(posedge mclk_in);
      gp_input_set_in <= 0;
      step(4);
      chk("input status", gp_input_status_out, g);
      chk("input irq", irq_out, |(g & r));
      clr();
      wr(8'h2A, 8'h0E);
      g = rnd();
      wr(8'h29, g);
      r = rnd();
      grouped_sensor_en_in <= r[6:0];
      sleep_in <= 1;
      // Touch only once the sleep sample select has settled
      step(3);
      button_touch_in <= 7'h7F;
      step(4);
      chk("sleep buttons", button_sample_out, g[6:0]);
      chk("sleep grouped", grouped_sample_out, g[7] ? r[6:0] : 7'h00);
      chk("sleep status", touch_status_out[6:0], g[6:0]);
      sleep_in <= 0;
      clr();
    end
    grouped_sensor_en_in <= 7'h7F;
    $display("input and sleep tests done");
    // Spare configuration bits read back as zero
    wr(8'h2A, 8'h7E);
    rd(8'h2A);
    chk("config readback", r, 8'h0E);
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      g = rnd();
      wr(8'h2A, 8'(c));
      button_touch_in <= r[6:0];
      grouped_touch_in <= g[6:0];
      step(4);
      chk("button multi", button_multi_event_out, $countones(r[6:0]) > c / 4 + 1);
      chk("grouped multi", grouped_multi_event_out, $countones(g[6:0]) > glim(2'(c)));
    end
    clr();
    wr(8'h2A, 8'h80);
    button_touch_in <= 7'h06;
    step(6);
    chk("blocked", touch_status_out[6:0], 7'h02);
    button_touch_in <= 7'h04;
    step(4);
    chk("unblocked", touch_status_out[2], 1);
    $display("multi touch tests done");
    report_and_stop();
  end
endmodule

// >>> verilog/tisg_irq_ctrl.sv
// Interrupt gating, sleep sampling select and multiple touch control
`timescale 1ns/1ps
module tisg_irq_ctrl (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       sleep_in,
  input  wire logic [6:0] button_touch_in,
  input  wire logic [6:0] grouped_touch_in,
  input  wire logic [6:0] grouped_sensor_en_in,
  input  wire logic [3:0] group_gesture_in,
  input  wire logic [7:0] gp_input_set_in,
  input  wire logic [7:0] status_clear_in,
  output logic      [7:0] touch_status_out,
  output logic      [7:0] gp_input_status_out,
  output logic      [6:0] button_sample_out,
  output logic      [6:0] grouped_sample_out,
  output logic            button_multi_event_out,
  output logic            grouped_multi_event_out,
  output logic            irq_out
);
  logic [7:0] touch_group_irq_enable;
  logic [7:0] gp_input_irq_enable;
  logic [7:0] sleep_sampling_select;
  logic [7:0] simultaneous_touch_config;
  tisg_pkg::tisg_mode_t mode;
  logic [6:0] button_accepted;
  logic [6:0] grouped_accepted;
  logic [6:0] button_live;
  logic [6:0] grouped_live;
  logic [7:0] touch_event;
  logic [7:0] next_touch_status;
  logic [7:0] next_gp_status;
  logic       button_multi;
  logic       grouped_multi;

  // Button limit: code n stands for n+1 simultaneous touches
  function automatic logic [2:0] button_limit(input logic [1:0] code);
    button_limit = {1'b0, code} + 3'h1;
  endfunction

  // Grouped limit: codes 0..3 stand for 2, 3, 4, 1
  function automatic logic [2:0] grouped_limit(input logic [1:0] code);
    case (code)
      2'h0:    grouped_limit = 3'h2;
      2'h1:    grouped_limit = 3'h3;
      2'h2:    grouped_limit = 3'h4;
      2'h3:    grouped_limit = 3'h1;
      default: grouped_limit = 3'h1;
    endcase
  endfunction

  // Register writes
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      touch_group_irq_enable    <= tisg_pkg::RST_TOUCH_GROUP_IRQ_ENABLE;
      gp_input_irq_enable       <= tisg_pkg::RST_GP_INPUT_IRQ_ENABLE;
      sleep_sampling_select     <= tisg_pkg::RST_SLEEP_SAMPLING_SELECT;
      simultaneous_touch_config <= tisg_pkg::RST_SIMULTANEOUS_TOUCH_CFG;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        tisg_pkg::ADDR_TOUCH_GROUP_IRQ_ENABLE: touch_group_irq_enable <= reg_wdata_in;
        tisg_pkg::ADDR_GP_INPUT_IRQ_ENABLE:    gp_input_irq_enable    <= reg_wdata_in;
        tisg_pkg::ADDR_SLEEP_SAMPLING_SELECT:  sleep_sampling_select  <= reg_wdata_in;
        tisg_pkg::ADDR_SIMULTANEOUS_TOUCH_CFG: begin
          simultaneous_touch_config <= reg_wdata_in & 8'h8F; // Reserved bits stay zero
        end
        default: ;
      endcase
    end
  end

  // Register reads, unmapped addresses return zero
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        tisg_pkg::ADDR_TOUCH_GROUP_IRQ_ENABLE: reg_rdata_out <= touch_group_irq_enable;
        tisg_pkg::ADDR_GP_INPUT_IRQ_ENABLE:    reg_rdata_out <= gp_input_irq_enable;
        tisg_pkg::ADDR_SLEEP_SAMPLING_SELECT:  reg_rdata_out <= sleep_sampling_select;
        tisg_pkg::ADDR_SIMULTANEOUS_TOUCH_CFG: reg_rdata_out <= simultaneous_touch_config;
        default:                               reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Operating mode follows the sleep request
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      mode <= tisg_pkg::TISG_ACTIVE;
    end else begin
      case (mode)
        tisg_pkg::TISG_ACTIVE: if (sleep_in) mode <= tisg_pkg::TISG_SLEEP;
        tisg_pkg::TISG_SLEEP:  if (!sleep_in) mode <= tisg_pkg::TISG_ACTIVE;
        default:               mode <= tisg_pkg::TISG_ACTIVE;
      endcase
    end
  end

  // Sensor sampling selects; in sleep only chosen sensors run
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      button_sample_out  <= 7'h00;
      grouped_sample_out <= 7'h00;
    end else if (mode == tisg_pkg::TISG_SLEEP) begin
      button_sample_out  <= sleep_sampling_select[6:0];
      grouped_sample_out <= sleep_sampling_select[tisg_pkg::GROUP_BIT] ?
                            grouped_sensor_en_in : 7'h00;
    end else begin
      button_sample_out  <= 7'h7F;
      grouped_sample_out <= grouped_sensor_en_in;
    end
  end

  // Touches only count from sensors currently sampled
  assign button_live  = button_touch_in & button_sample_out;
  assign grouped_live = grouped_touch_in & grouped_sample_out;

  // Button class limiter
  tisg_touch_limit u_button_limit (
    .mclk_in         (mclk_in),
    .resetn_in       (resetn_in),
    .block_en_in     (simultaneous_touch_config[tisg_pkg::BLOCK_EN_BIT]),
    .limit_in        (button_limit(simultaneous_touch_config[3:2])),
    .touch_in        (button_live),
    .accepted_out    (button_accepted),
    .multi_event_out (button_multi)
  );

  // Grouped class limiter
  tisg_touch_limit u_grouped_limit (
    .mclk_in         (mclk_in),
    .resetn_in       (resetn_in),
    .block_en_in     (simultaneous_touch_config[tisg_pkg::BLOCK_EN_BIT]),
    .limit_in        (grouped_limit(simultaneous_touch_config[1:0])),
    .touch_in        (grouped_live),
    .accepted_out    (grouped_accepted),
    .multi_event_out (grouped_multi)
  );

  // Status events: accepted button touches plus a grouped gesture while a grouped touch is accepted
  always_comb begin
    touch_event = {(|group_gesture_in) & (|grouped_accepted), button_accepted};
    next_touch_status = (touch_status_out & ~status_clear_in) | touch_event;
    next_gp_status    = (gp_input_status_out & ~status_clear_in) | gp_input_set_in;
  end

  // Sticky status, set wins over clear
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      touch_status_out    <= 8'h00;
      gp_input_status_out <= 8'h00;
    end else begin
      touch_status_out    <= next_touch_status;
      gp_input_status_out <= next_gp_status;
    end
  end

  // Multiple touch flags
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      button_multi_event_out  <= 1'b0;
      grouped_multi_event_out <= 1'b0;
    end else begin
      button_multi_event_out  <= button_multi;
      grouped_multi_event_out <= grouped_multi;
    end
  end

  // Interrupt pin: only enabled status bits drive it
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_touch_status & touch_group_irq_enable) |
                 |(next_gp_status & gp_input_irq_enable);
    end
  end
endmodule

// >>> verilog/tisg_touch_limit.sv
// Per-class simultaneous touch limiter with sticky blocking
`timescale 1ns/1ps
module tisg_touch_limit (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       block_en_in,
  input  wire logic [2:0] limit_in,
  input  wire logic [6:0] touch_in,
  output logic      [6:0] accepted_out,
  output logic            multi_event_out
);
  logic [6:0] accepted;
  logic [6:0] next_accepted;
  logic [3:0] total;

  // Count raw touches and choose accepted set, held sensors kept first
  always_comb begin
    logic [3:0] kept;
    kept = 4'h0;
    total = 4'h0;
    next_accepted = 7'h00;
    for (int i = 0; i < 7; i++) begin
      total = total + {3'h0, touch_in[i]};
      if (accepted[i] && touch_in[i]) begin
        next_accepted[i] = 1'b1;
        kept = kept + 4'h1;
      end
    end
    for (int i = 0; i < 7; i++) begin
      if (touch_in[i] && !next_accepted[i] && (kept < {1'b0, limit_in})) begin
        next_accepted[i] = 1'b1;
        kept = kept + 4'h1;
      end
    end
    if (!block_en_in) begin
      next_accepted = touch_in;
    end
  end

  // Accepted set and event flag registers
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      accepted        <= 7'h00;
      multi_event_out <= 1'b0;
    end else begin
      accepted        <= next_accepted;
      multi_event_out <= (total > {1'b0, limit_in});
    end
  end

  assign accepted_out = accepted;
endmodule
